// ==== hw/three_wire_serial_shifter.sv ====
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
module three_wire_serial_shifter (
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_out,
  output logic             so_out,
  output logic             so_oe_out,
  input  wire logic        si_in,
  output logic             si_out,
  output logic             si_oe_out,
  output logic             irq_out
);
  import serial_shifter_pkg::*;

  serial_shifter_pkg::ctrl_t ctrl_reg;
  serial_shifter_pkg::ctrl_t ctrl_next;
  logic [7:0]  shift_reg;
  logic [7:0]  div_reg;
  logic [7:0]  div_cnt_reg;
  logic [7:0]  irq_stat_reg;
  logic [7:0]  irq_stat_next;
  logic [7:0]  irq_mask_reg;
  logic [2:0]  latch_reg;
  logic [3:0]  count_reg;
  logic        sck_int_reg;
  logic        so_bit_reg;
  logic [2:0]  sck_sync_reg;
  logic [2:0]  si_sync_reg;
  logic        sck_level_reg;
  logic [31:0] rdata_next;

  function automatic logic wait_hit(input logic [1:0] sel,
                                    input logic       rise,
                                    input logic [3:0] cnt_after);
    logic hit;
    hit = 1'b0;
    if ((sel == WAIT_BYTE) || (sel == WAIT_BYTE_ALT)) begin
      hit = rise && (cnt_after == BYTE_BITS);
    end else if (sel == WAIT_BIT) begin
      hit = rise;
    end
    return hit;
  endfunction

  // mode decode
  wire        run_w    = ctrl_reg.serial_run_flag;
  wire        master_w = ctrl_reg.master_select;
  wire        tx_w     = ctrl_reg.transmit_select;
  wire [1:0]  wsel_w   = {ctrl_reg.wait_condition_sel_hi, ctrl_reg.wait_condition_sel_lo};

  // apb decode
  wire apb_access = psel_in & penable_in;
  wire apb_done   = apb_access & pready_out;
  wire wr_w       = apb_done & pwrite_in;
  wire hit_ctrl   = (paddr_in == OFF_CTRL);
  wire hit_shift  = (paddr_in == OFF_SHIFT);
  wire hit_port   = (paddr_in == OFF_PORT);
  wire hit_status = (paddr_in == OFF_STATUS);
  wire hit_istat  = (paddr_in == OFF_IRQ_STAT);
  wire hit_imask  = (paddr_in == OFF_IRQ_MASK);
  wire hit_div    = (paddr_in == OFF_DIV);
  wire mapped     = hit_ctrl | hit_shift | hit_port | hit_status | hit_istat | hit_imask | hit_div;
  wire pready_next  = apb_access & ~pready_out;
  wire pslverr_next = pready_next & ~mapped;
  wire wr_ctrl    = wr_w & hit_ctrl;
  wire wr_shift   = wr_w & hit_shift;
  wire run_start  = wr_ctrl & pwdata_in[0];

  // internal shift clock: half period of div_reg+1 system cycles
  wire half_done = (div_cnt_reg == div_reg);
  wire int_tick  = run_w & master_w & half_done;
  wire int_rise  = int_tick & ~sck_int_reg;
  wire int_fall  = int_tick & sck_int_reg;

  // external clock edge counts once second and third stages agree on a new level
  wire sck_agree = (sck_sync_reg[1] == sck_sync_reg[2]);
  wire ext_rise  = sck_agree & sck_sync_reg[2] & ~sck_level_reg;
  wire ext_fall  = sck_agree & ~sck_sync_reg[2] & sck_level_reg;
  wire clk_rise  = master_w ? int_rise : ext_rise;
  wire clk_fall  = master_w ? int_fall : ext_fall;
  wire si_level  = si_sync_reg[2];

  wire       shift_rise = run_w & clk_rise;
  wire       shift_fall = run_w & clk_fall & tx_w;
  wire [3:0] count_next = count_reg + 4'h1;
  wire       hw_stop    = run_w & wait_hit(wsel_w, clk_rise, count_next);

  wire [7:0] irq_events = {6'h00, shift_rise, hw_stop};
  wire [7:0] irq_clear  = (wr_w & hit_istat) ? pwdata_in[7:0] : 8'h00;

  // pin drive selection
  wire sck_oe_next = master_w | ctrl_reg.clock_pin_direction;
  wire sck_o_next  = master_w ? sck_int_reg : latch_reg[LATCH_CLK];
  wire so_oe_next  = tx_w | ctrl_reg.out_pin_direction;
  wire so_o_next   = tx_w ? so_bit_reg : latch_reg[LATCH_OUT];
  wire si_oe_next  = ctrl_reg.in_pin_direction;
  wire si_o_next   = latch_reg[LATCH_IN];

  // run flag: software write lands after the hardware stop so a set wins
  always_comb begin
    ctrl_next = ctrl_reg;
    if (hw_stop) begin
      ctrl_next.serial_run_flag = 1'b0;
    end
    if (wr_ctrl) begin
      ctrl_next = ctrl_t'(pwdata_in[7:0]);
    end
  end

  always_comb begin
    irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_events;
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_next[7:0] = ctrl_reg;
    end else if (hit_shift) begin
      rdata_next[7:0] = shift_reg;
    end else if (hit_port) begin
      rdata_next[2:0] = latch_reg;
    end else if (hit_status) begin
      rdata_next[3:0]      = count_reg;
      rdata_next[STAT_SCK] = sck_sync_reg[2];
      rdata_next[STAT_SI]  = si_level;
      rdata_next[STAT_RUN] = run_w;
    end else if (hit_istat) begin
      rdata_next[7:0] = irq_stat_reg;
    end else if (hit_imask) begin
      rdata_next[7:0] = irq_mask_reg;
    end else if (hit_div) begin
      rdata_next[7:0] = div_reg;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else if (ce_in) begin
      pready_out  <= pready_next;
      pslverr_out <= pslverr_next;
      prdata_out  <= pready_next ? rdata_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ctrl_reg     <= ctrl_t'(CTRL_RESET);
      div_reg      <= DIV_RESET;
      latch_reg    <= LATCH_RESET;
      irq_mask_reg <= IRQ_RESET;
      irq_stat_reg <= IRQ_RESET;
      irq_out      <= 1'b0;
    end else if (ce_in) begin
      ctrl_reg     <= ctrl_next;
      irq_stat_reg <= irq_stat_next;
      irq_out      <= |(irq_stat_reg & irq_mask_reg);
      if (wr_w & hit_div) begin
        div_reg <= pwdata_in[7:0];
      end
      if (wr_w & hit_port) begin
        latch_reg <= pwdata_in[2:0];
      end
      if (wr_w & hit_imask) begin
        irq_mask_reg <= pwdata_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sck_sync_reg  <= 3'h7;
      si_sync_reg   <= 3'h0;
      sck_level_reg <= 1'b1;
    end else if (ce_in) begin
      sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
      si_sync_reg  <= {si_sync_reg[1:0], si_in};
      if (sck_agree) begin
        sck_level_reg <= sck_sync_reg[2];
      end
    end
  end

  // shift clock generator idles high outside a master transfer
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      div_cnt_reg <= 8'h00;
      sck_int_reg <= 1'b1;
    end else if (ce_in) begin
      if (!run_w || !master_w || run_start) begin
        div_cnt_reg <= 8'h00;
        sck_int_reg <= 1'b1;
      end else if (half_done) begin
        div_cnt_reg <= 8'h00;
        sck_int_reg <= ~sck_int_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      count_reg  <= 4'h0;
      shift_reg  <= SHIFT_RESET;
      so_bit_reg <= 1'b0;
    end else if (ce_in) begin
      if (run_start) begin
        count_reg <= 4'h0;
      end else if (clk_rise) begin
        count_reg <= count_next;
      end
      if (wr_shift) begin
        shift_reg <= pwdata_in[7:0];
      end else if (shift_rise) begin
        shift_reg <= {shift_reg[6:0], si_level};
      end
      if (shift_fall) begin
        so_bit_reg <= shift_reg[7];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sck_out    <= 1'b1;
      sck_oe_out <= 1'b0;
      so_out     <= 1'b0;
      so_oe_out  <= 1'b0;
      si_out     <= 1'b0;
      si_oe_out  <= 1'b0;
    end else if (ce_in) begin
      sck_out    <= sck_o_next;
      sck_oe_out <= sck_oe_next;
      so_out     <= so_o_next;
      so_oe_out  <= so_oe_next;
      si_out     <= si_o_next;
      si_oe_out  <= si_oe_next;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in || !ce_in);

  property p_run_start;
    run_start |=> run_w && (count_reg == 4'h0);
  endproperty
  a_run_start: assert property (p_run_start) else $error("run flag not set by write");

  property p_idle_no_shift;
    (!run_w && !wr_shift) |=> $stable(shift_reg);
  endproperty
  a_idle_no_shift: assert property (p_idle_no_shift) else $error("shift while idle");

  property p_byte_stop;
    (run_w && (wsel_w == WAIT_BYTE) && clk_rise && (count_reg == 4'h7) && !wr_ctrl)
      |=> !run_w;
  endproperty
  a_byte_stop: assert property (p_byte_stop) else $error("no stop after eighth edge");

  property p_no_early_stop;
    (run_w && (wsel_w == WAIT_NONE) && !wr_ctrl) |=> run_w;
  endproperty
  a_no_early_stop: assert property (p_no_early_stop) else $error("run cleared without cause");

  property p_count;
    (clk_rise && !run_start) |=> (count_reg == $past(count_reg) + 4'h1);
  endproperty
  a_count: assert property (p_count) else $error("counter missed an edge");

  property p_tx_msb;
    (shift_fall && tx_w) ##1 tx_w |=> (so_out == $past(shift_reg[7], 2));
  endproperty
  a_tx_msb: assert property (p_tx_msb) else $error("transmit bit not msb");

  property p_rx_fill;
    (shift_rise && !wr_shift)
      |=> (shift_reg == {$past(shift_reg[6:0]), $past(si_level)});
  endproperty
  a_rx_fill: assert property (p_rx_fill) else $error("receive bit not in lsb");

  property p_master_idle_high;
    (master_w && !run_w)[*3] |-> (sck_out && sck_oe_out);
  endproperty
  a_master_idle_high: assert property (p_master_idle_high) else $error("idle clock not high");

  property p_master_drive;
    (master_w && run_w) ##1 master_w |-> sck_oe_out && (sck_out == $past(sck_int_reg));
  endproperty
  a_master_drive: assert property (p_master_drive) else $error("shift clock not driven");

  property p_slave_float;
    (!master_w && !ctrl_reg.clock_pin_direction) |=> !sck_oe_out;
  endproperty
  a_slave_float: assert property (p_slave_float) else $error("slave drives clock pin");

  property p_tx_hold;
    (tx_w && !run_w) |=> $stable(so_bit_reg);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("output moved while idle");

  property p_rx_port;
    (!tx_w && !ctrl_reg.out_pin_direction) |=> !so_oe_out;
  endproperty
  a_rx_port: assert property (p_rx_port) else $error("receive drives output pin");

  property p_si_dir;
    ctrl_reg.in_pin_direction |=> si_oe_out && (si_out == $past(latch_reg[LATCH_IN]));
  endproperty
  a_si_dir: assert property (p_si_dir) else $error("input pin latch not driven");

  property p_cov_master_done;
    master_w && tx_w && hw_stop;
  endproperty
  c_cov_master_done: cover property (p_cov_master_done);

  property p_cov_slave_done;
    !master_w && !tx_w && hw_stop;
  endproperty
  c_cov_slave_done: cover property (p_cov_slave_done);

  property p_cov_irq;
    !irq_out ##1 irq_out;
  endproperty
  c_cov_irq: cover property (p_cov_irq);

endmodule

// ==== hw/serial_shifter_pkg.sv ====
package serial_shifter_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SHIFT    = 8'h04;
  localparam logic [7:0] OFF_PORT     = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_DIV      = 8'h18;

  // wait-condition select encodings
  localparam logic [1:0] WAIT_NONE     = 2'h0;
  localparam logic [1:0] WAIT_BYTE     = 2'h1;
  localparam logic [1:0] WAIT_BIT      = 2'h2;
  localparam logic [1:0] WAIT_BYTE_ALT = 2'h3;

  localparam logic [3:0] BYTE_BITS = 4'h8;

  // port latch bit positions
  localparam int LATCH_CLK = 0;
  localparam int LATCH_OUT = 1;
  localparam int LATCH_IN  = 2;

  // interrupt status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RISE = 1;

  // status register field positions
  localparam int STAT_SCK = 4;
  localparam int STAT_SI  = 5;
  localparam int STAT_RUN = 6;

  // reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] DIV_RESET   = 8'h04;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [2:0] LATCH_RESET = 3'h0;
  localparam logic [7:0] IRQ_RESET   = 8'h00;

  typedef struct packed {
    logic       in_pin_direction;
    logic       out_pin_direction;
    logic       clock_pin_direction;
    logic       transmit_select;
    logic       master_select;
    logic       wait_condition_sel_hi;
    logic       wait_condition_sel_lo;
    logic       serial_run_flag;
  } ctrl_t;

endpackage

// ==== dv/serial_peer.sv ====
`timescale 1ns/10ps
module serial_peer (
  input  wire logic       sck_pin_in,
  input  wire logic       so_pin_in,
  output logic            sck_out,
  output logic            si_out,
  output logic [7:0]      rx_byte_out
);
  logic [7:0] tx;
  int         idx;
  initial begin
    sck_out = 1'b1;
    si_out = 1'b0;
    rx_byte_out = 8'h00;
    tx = 8'h00;
    idx = 0;
  end
  // next bit goes out on each falling edge, msb first
  always @(negedge sck_pin_in) begin
    si_out = tx[7 - idx];
    idx = (idx + 1) % 8;
  end
  // read late in the high phase, past the device's pin delay
  always @(posedge sck_pin_in) begin
    #95;
    rx_byte_out = {rx_byte_out[6:0], so_pin_in};
  end
  task automatic load(input logic [7:0] b);
    tx = b;
    idx = 0;
  endtask
  // clock idles high and runs only inside a frame; data bit toggles after
  task automatic frame();
    // keep pin edges clear of the system clock edges
    #7;
    repeat (8) begin
      #100 sck_out = 1'b0;
      #100 sck_out = 1'b1;
    end
    #200 si_out = ~si_out;
  endtask
endmodule

// ==== dv/three_wire_serial_shifter_tb.sv ====
`timescale 1ns/10ps
module three_wire_serial_shifter_tb;
  import serial_shifter_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, sck_o, sck_oe, so_o, so_oe, si_o, si_oe, irq;
  logic        p_sck, p_si, sck_w, si_w, so_w;
  logic [7:0]  p_rx;
  logic [31:0] regm [0:6];
  logic [31:0] seed = 32'd87822;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  assign sck_w = sck_oe ? sck_o : p_sck;
  assign si_w = si_oe ? si_o : p_si;
  assign so_w = so_oe ? so_o : clk_sys_in;
  three_wire_serial_shifter dut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(ce),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .sck_in(sck_w),
    .sck_out(sck_o), .sck_oe_out(sck_oe), .so_out(so_o), .so_oe_out(so_oe),
    .si_in(si_w), .si_out(si_o), .si_oe_out(si_oe), .irq_out(irq));
  serial_peer u_peer (.sck_pin_in(sck_w), .so_pin_in(so_w), .sck_out(p_sck),
    .si_out(p_si), .rx_byte_out(p_rx));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_mismatch++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    if (a == OFF_IRQ_STAT) regm[4] = regm[4] & ~d;
    else regm[a[4:2]] = d & 32'hff;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, regm[a[4:2]] & m);
    chk(32'(e), 32'h0);
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(irq), 32'(v));
  endtask
  task automatic xfer(input logic [7:0] c);
    logic [7:0] tb, pb;
    int         nb, n;
    seed = lfsr(seed);
    tb = seed[7:0];
    pb = seed[15:8];
    nb = (c[2:1] == WAIT_BIT) ? 1 : 8;
    n = 0;
    u_peer.load(pb);
    wr(OFF_SHIFT, 32'(tb));
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CTRL, 32'(c));
    rd(OFF_CTRL, 32'hff);
    if (!c[3]) u_peer.frame();
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (irq !== 1'b1) n_mismatch++;
    regm[0] = 32'(c) & 32'hfe;
    regm[1] = ((32'(tb) << nb) | (32'(pb) >> (8 - nb))) & 32'hff;
    regm[3] = 32'(nb);
    regm[4] = 32'h3;
    rd(OFF_CTRL, 32'hff);
    rd(OFF_SHIFT, 32'hff);
    rd(OFF_STATUS, 32'h4f);
    rd(OFF_IRQ_STAT, 32'hff);
    if (c[4]) begin
      chk(32'(p_rx), 32'(tb));
      chk(32'({so_oe, so_o}), 32'({1'b1, tb[0]}));
    end
    else chk(32'(so_oe), 32'h0);
    chk(32'({sck_oe, sck_o & c[3]}), 32'({c[3], c[3]}));
    wr(OFF_IRQ_STAT, 32'h3);
    irq_is(1'b0);
    $display("transfer with control %h done", c);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  tbl [0:5];
    logic [31:0] hold;
    tbl = '{8'h1b, 8'h0b, 8'h0f, 8'h0d, 8'h13, 8'h03};
    regm = '{32'h0, 32'h0, 32'h0, 32'h10, 32'h0, 32'h0, 32'h4};
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'hff);
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    $display("reset values done");
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      wr(OFF_PORT, seed & 32'h7);
      wr(OFF_CTRL, 32'he0);
      repeat (2) @(posedge clk_sys_in);
      chk(32'({sck_oe, sck_o, so_oe, so_o, si_oe, si_o}),
          32'({1'b1, seed[0], 1'b1, seed[1], 1'b1, seed[2]}));
    end
    wr(OFF_CTRL, 32'h00);
    repeat (2) @(posedge clk_sys_in);
    chk(32'({sck_oe, so_oe, si_oe}), 32'h0);
    $display("port latch done");
    for (int i = 0; i < 6; i++) xfer(tbl[i]);
    wr(OFF_CTRL, 32'h02);
    u_peer.frame();
    rd(OFF_SHIFT, 32'hff);
    rd(OFF_IRQ_STAT, 32'hff);
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_CTRL, 32'h09);
    repeat (200) @(posedge clk_sys_in);
    rd(OFF_CTRL, 32'hff);
    regm[4] = 32'h2;
    rd(OFF_IRQ_STAT, 32'hff);
    irq_is(1'b0);
    wr(OFF_IRQ_MASK, 32'h2);
    irq_is(1'b1);
    // free-running clock must stop while the clock enable is low
    ce <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    hold = 32'({sck_o, sck_oe, so_oe, irq});
    repeat (20) @(posedge clk_sys_in);
    chk(32'({sck_o, sck_oe, so_oe, irq}), hold);
    ce <= 1'b1;
    $display("clock enable freeze done");
    wr(OFF_CTRL, 32'h08);
    repeat (3) @(posedge clk_sys_in);
    chk(32'({sck_oe, sck_o}), 32'h3);
    wr(OFF_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    $display("idle and free-running done");
    results();
  end
endmodule
